// ==== core/spi_pin_pkg.sv ====
package spi_pin_pkg;

   localparam int unsigned WORD_BITS            = 8;
   localparam int unsigned FIFO_WORDS           = 8;
   localparam int unsigned BUSY_CNT_W           = 24;
   localparam int unsigned WRITE_CYCLES_DEFAULT = 64;

   localparam logic [2:0] BIT_CNT_RESET = 3'h0;
   localparam logic [2:0] BIT_CNT_LAST  = 3'h7;
   localparam logic [7:0] WORD_RESET    = 8'h00;

   typedef enum logic [1:0] {
      ST_STANDBY,
      ST_SELECTED,
      ST_WRITE
   } dev_state_e;

   typedef struct packed {
      logic                  cs_s1;
      logic                  cs_s2;
      logic                  hold_s1;
      logic                  hold_s2;
      logic                  wp_s1;
      logic                  wp_s2;
      logic                  tg_s1;
      logic                  tg_s2;
      logic                  tg_prev;
      logic                  armed;
      logic                  frame_ok;
      dev_state_e            state;
      logic [BUSY_CNT_W-1:0] busy_cnt;
      logic                  status_ok;
      logic                  wel;
      logic                  write_start;
      logic                  so_oe;
      logic                  standby;
      logic                  busy;
      logic [7:0]            rx_data;
      logic                  rx_push;
      logic                  overrun;
      logic [7:0]            tx_data;
      logic                  tx_ready;
   } core_state_s;

   localparam core_state_s CORE_RESET = '{
      cs_s1: 1'b1, cs_s2: 1'b1, hold_s1: 1'b1, hold_s2: 1'b1,
      wp_s1: 1'b1, wp_s2: 1'b1, tg_s1: 1'b0, tg_s2: 1'b0,
      tg_prev: 1'b0, armed: 1'b0, frame_ok: 1'b0, state: ST_STANDBY,
      busy_cnt: '0, status_ok: 1'b0, wel: 1'b0, write_start: 1'b0,
      so_oe: 1'b0, standby: 1'b1, busy: 1'b0, rx_data: WORD_RESET,
      rx_push: 1'b0, overrun: 1'b0, tx_data: WORD_RESET,
      tx_ready: 1'b1};

   typedef struct packed {
      logic [2:0] bit_cnt;
      logic [7:0] shift;
   } link_rx_s;

   typedef struct packed {
      logic [7:0] word;
      logic       tgl;
   } link_word_s;

   typedef struct packed {
      logic       paused;
      logic [7:0] shift;
      logic       so;
   } link_tx_s;

endpackage

// ==== core/spi_pin_dev.sv ====
// Functional notes
// - Select low selects the device; select high deselects into Standby.
// - A started programming cycle finishes; Standby follows only after it.
// - Data output is high impedance whenever the device is deselected.
// - Select rising after a valid write sequence starts the write cycle.
// - Select counts as seen high at reset, so sequences are accepted right after it.
// - Output data changes after each falling serial clock edge.
// - Input data is sampled on each rising serial clock edge.
// - Protect pin low with enable bit set refuses status writes.
// - Protect pin high lets every function, status writes included, run.
// - Protect pin falling during a running write leaves that write alone.
// - Enable bit clear makes the protect pin ignored entirely.
// - Pause low mid-sequence freezes the sequence, which later continues.
// - Pause lowered with clock high takes effect at next falling edge.
// - While paused, data input, clock and output transitions are ignored.
// - Resume needs pause raised while clock is low; pause raised with clock high resumes here at the next falling edge.
// - Pause low at any time puts the data output in high impedance.
// - Power-on: Standby, write enable latch clear, output high impedance.
`timescale 1ns/1ns

module spi_word_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst_b,
   input  wire logic             i_en,
   input  wire logic [WIDTH-1:0] i_in_data,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   output logic      [WIDTH-1:0] o_out_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int unsigned CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [CW-1:0]               cnt;
      logic [WIDTH-1:0]            out_data;
      logic                        out_valid;
   } fifo_state_s;

   fifo_state_s f;
   fifo_state_s n;
   logic        put;
   logic        load;
   logic        full;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign o_in_ready  = !full;
   assign o_out_data  = f.out_data;
   assign o_out_valid = f.out_valid;

   always_comb begin
      n    = f;
      // The output register is one of the DEPTH words, so it counts here.
      full = (f.cnt == CW'(DEPTH))
         || (f.out_valid && f.cnt == CW'(DEPTH - 1));
      put  = i_in_valid && !full;
      load = (!f.out_valid || i_out_ready) && (f.cnt != '0);
      if (put) begin
         n.mem[f.wr] = i_in_data;
         n.wr        = bump(f.wr);
      end
      if (!f.out_valid || i_out_ready) begin
         n.out_valid = load;
      end
      if (load) begin
         n.out_data = f.mem[f.rd];
         n.rd       = bump(f.rd);
      end
      n.cnt = f.cnt + CW'(put) - CW'(load);
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         f <= '0;
      end else if (i_en) begin
         f <= n;
      end
   end
endmodule // spi_word_fifo

module spi_pin_dev #(
   parameter int unsigned WRITE_CYCLES = spi_pin_pkg::WRITE_CYCLES_DEFAULT,
   parameter int unsigned RX_DEPTH     = spi_pin_pkg::FIFO_WORDS
) (
   input  wire logic       i_core_clk,
   input  wire logic       i_rst_b,
   input  wire logic       i_core_en,
   input  wire logic       i_sck,
   input  wire logic       i_cs_b,
   input  wire logic       i_si,
   input  wire logic       i_hold_b,
   input  wire logic       i_wp_b,
   output logic            o_so,
   output logic            o_so_oe,
   input  wire logic       i_read_mode,
   input  wire logic       i_write_seq_ok,
   input  wire logic       i_status_write,
   input  wire logic       i_protect_pin_enable_bit,
   input  wire logic       i_wren,
   input  wire logic [7:0] i_tx_data,
   input  wire logic       i_tx_valid,
   output logic            o_tx_ready,
   output logic      [7:0] o_rx_data,
   output logic            o_rx_valid,
   input  wire logic       i_rx_ready,
   output logic            o_overrun,
   input  wire logic       i_overrun_clr,
   output logic            o_standby,
   output logic            o_write_busy,
   output logic            o_write_start,
   output logic            o_status_write_en,
   output logic            o_wel
);
   import spi_pin_pkg::*;

   core_state_s c;
   core_state_s n;
   link_rx_s    lr;
   link_rx_s    lr_n;
   link_word_s  lw;
   link_word_s  lw_n;
   link_tx_s    lt;
   link_tx_s    lt_n;
   logic        frame_rst_b;
   logic        fifo_in_ready;

   // Serial-clock domain. Select, data and pause are launched by the
   // master against this clock, so they are sampled here directly; the
   // frame logic is cleared by select itself because the clock stops
   // between frames.
   assign frame_rst_b = i_rst_b && !i_cs_b;

   always_comb begin
      lr_n = lr;
      lw_n = lw;
      if (i_hold_b) begin
         lr_n.shift   = {lr.shift[6:0], i_si};
         lr_n.bit_cnt = lr.bit_cnt + 3'h1;
         if (lr.bit_cnt == BIT_CNT_LAST) begin
            lw_n.word = lr_n.shift;
            lw_n.tgl  = !lw.tgl;
         end
      end
   end

   always_ff @(posedge i_sck or negedge frame_rst_b) begin
      if (!frame_rst_b) begin
         lr <= '{bit_cnt: BIT_CNT_RESET, shift: WORD_RESET};
      end else begin
         lr <= lr_n;
      end
   end

   // The word and its toggle survive deselect so that the core never
   // sees a spurious byte event when a frame is cut short.
   always_ff @(posedge i_sck or negedge i_rst_b) begin
      if (!i_rst_b) begin
         lw <= '{word: WORD_RESET, tgl: 1'b0};
      end else if (!i_cs_b) begin
         lw <= lw_n;
      end
   end

   always_comb begin
      lt_n        = lt;
      lt_n.paused = !i_hold_b;
      if (i_hold_b) begin
         if (lr.bit_cnt == BIT_CNT_RESET) begin
            lt_n.so    = c.tx_data[7];
            lt_n.shift = {c.tx_data[6:0], 1'b0};
         end else begin
            lt_n.so    = lt.shift[7];
            lt_n.shift = {lt.shift[6:0], 1'b0};
         end
      end
   end

   always_ff @(negedge i_sck or negedge frame_rst_b) begin
      if (!frame_rst_b) begin
         lt <= '{paused: 1'b0, shift: WORD_RESET, so: 1'b0};
      end else begin
         lt <= lt_n;
      end
   end

   assign o_so = lt.so;

   // Core domain.
   always_comb begin
      n             = c;
      n.write_start = 1'b0;
      n.rx_push     = 1'b0;
      n.cs_s1       = i_cs_b;
      n.cs_s2       = c.cs_s1;
      n.hold_s1     = i_hold_b;
      n.hold_s2     = c.hold_s1;
      n.wp_s1       = i_wp_b;
      n.wp_s2       = c.wp_s1;
      n.tg_s1       = lw.tgl;
      n.tg_s2       = c.tg_s1;
      n.tg_prev     = c.tg_s2;
      if (c.cs_s2) begin
         n.armed = 1'b1;
      end
      if (c.state != ST_SELECTED && !c.cs_s2 && c.cs_s1 == 1'b0) begin
         n.frame_ok = c.armed || n.frame_ok;
      end
      if (c.cs_s2) begin
         n.frame_ok = n.frame_ok && (c.state == ST_SELECTED);
      end
      // The word is stable for a whole byte time once its toggle is seen.
      if (c.tg_s2 != c.tg_prev) begin
         n.rx_data  = lw.word;
         n.rx_push  = c.frame_ok;
         n.tx_ready = 1'b1;
      end
      if (i_tx_valid && c.tx_ready) begin
         n.tx_data  = i_tx_data;
         n.tx_ready = 1'b0;
      end
      if (i_overrun_clr) begin
         n.overrun = 1'b0;
      end
      if (c.rx_push && !fifo_in_ready) begin
         n.overrun = 1'b1;
      end
      case (c.state)
         ST_STANDBY: begin
            if (!c.cs_s2 && c.armed) begin
               n.state    = ST_SELECTED;
               n.frame_ok = 1'b1;
            end
         end
         ST_SELECTED: begin
            if (c.cs_s2) begin
               if (c.frame_ok && i_write_seq_ok && c.wel) begin
                  n.state       = ST_WRITE;
                  n.busy_cnt    = BUSY_CNT_W'(WRITE_CYCLES - 1);
                  n.write_start = 1'b1;
                  // Latched once here, so later pin moves are ignored.
                  n.status_ok   = i_status_write && (c.wp_s2
                     || !i_protect_pin_enable_bit);
               end else begin
                  n.state = ST_STANDBY;
               end
            end
         end
         ST_WRITE: begin
            if (c.busy_cnt == '0) begin
               n.wel       = 1'b0;
               n.status_ok = 1'b0;
               n.state     = c.cs_s2 ? ST_STANDBY : ST_SELECTED;
            end else begin
               n.busy_cnt = c.busy_cnt - 1'b1;
            end
         end
         default: begin
            n.state = ST_STANDBY;
         end
      endcase
      if (i_wren) begin
         n.wel = 1'b1;
      end
      n.so_oe = !c.cs_s2 && c.hold_s2 && c.frame_ok
         && i_read_mode;
      n.standby = (n.state == ST_STANDBY);
      n.busy    = (n.state == ST_WRITE);
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         c <= CORE_RESET;
      end else if (i_core_en) begin
         c <= n;
      end
   end

   spi_word_fifo #(
      .WIDTH (WORD_BITS),
      .DEPTH (RX_DEPTH)
   ) u_rx_fifo (
      .i_clk       (i_core_clk),
      .i_rst_b     (i_rst_b),
      .i_en        (i_core_en),
      .i_in_data   (c.rx_data),
      .i_in_valid  (c.rx_push),
      .o_in_ready  (fifo_in_ready),
      .o_out_data  (o_rx_data),
      .o_out_valid (o_rx_valid),
      .i_out_ready (i_rx_ready)
   );

   assign o_so_oe           = c.so_oe;
   assign o_tx_ready        = c.tx_ready;
   assign o_overrun         = c.overrun;
   assign o_standby         = c.standby;
   assign o_write_busy      = c.busy;
   assign o_write_start     = c.write_start;
   assign o_status_write_en = c.status_ok;
   assign o_wel             = c.wel;

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_b);

   property p_deselect_hiz;
      i_core_en && c.cs_s2 |=> !o_so_oe;
   endproperty
   a_deselect_hiz: assert property (p_deselect_hiz)
      else $error("output enabled while deselected");

   property p_pause_hiz;
      i_core_en && !c.hold_s2 |=> !o_so_oe;
   endproperty
   a_pause_hiz: assert property (p_pause_hiz)
      else $error("output enabled while paused");

   property p_cycle_runs;
      i_core_en && c.state == ST_WRITE && c.busy_cnt != '0
         |=> o_write_busy && !o_standby;
   endproperty
   a_cycle_runs: assert property (p_cycle_runs)
      else $error("write cycle cut short");

   property p_write_start;
      i_core_en && c.state == ST_SELECTED && c.cs_s2 && c.frame_ok
         && i_write_seq_ok && c.wel |=> o_write_start ##1 o_write_busy;
   endproperty
   a_write_start: assert property (p_write_start)
      else $error("write cycle not started on select rise");

   property p_status_refused;
      $rose(o_write_start) |-> o_status_write_en == ($past(i_status_write)
         && ($past(c.wp_s2) || !$past(i_protect_pin_enable_bit)));
   endproperty
   a_status_refused: assert property (p_status_refused)
      else $error("status write permission wrong");

   property p_pin_ignored;
      $rose(o_write_start) && !$past(i_protect_pin_enable_bit)
         |-> o_status_write_en == $past(i_status_write);
   endproperty
   a_pin_ignored: assert property (p_pin_ignored)
      else $error("protect pin not ignored");

   property p_wp_no_effect;
      o_write_busy && !o_write_start && $past(o_write_busy)
         |-> $stable(o_status_write_en);
   endproperty
   a_wp_no_effect: assert property (p_wp_no_effect)
      else $error("running write disturbed");

   property p_standby_on_deselect;
      i_core_en && c.cs_s2 && c.cs_s1 && c.state == ST_STANDBY
         |=> o_standby [*2];
   endproperty
   a_standby_on_deselect: assert property (p_standby_on_deselect)
      else $error("not in standby while deselected");

   property p_armed_first;
      c.rx_push |-> c.armed;
   endproperty
   a_armed_first: assert property (p_armed_first)
      else $error("byte taken before select was seen");

   property p_sample_rise;
      @(posedge i_sck) disable iff (!frame_rst_b)
         i_hold_b |=> lr.bit_cnt == $past(lr.bit_cnt) + 3'h1;
   endproperty
   a_sample_rise: assert property (p_sample_rise)
      else $error("rising edge not sampled");

   property p_pause_freeze;
      @(posedge i_sck) disable iff (!frame_rst_b)
         !i_hold_b |=> $stable(lr.shift) && $stable(lr.bit_cnt);
   endproperty
   a_pause_freeze: assert property (p_pause_freeze)
      else $error("clock edge honoured while paused");

   c_write_cycle: cover property (o_write_start ##[1:300] o_standby);
   c_refused: cover property (o_write_start && !o_status_write_en);
   c_rx_byte: cover property (o_rx_valid && i_rx_ready);
   c_pause: cover property (!c.hold_s2 && !c.cs_s2 ##1 c.hold_s2);
endmodule // spi_pin_dev

// ==== verif/spi_host_model.sv ====
`timescale 1ns/1ns

module spi_host_model (
   output logic      o_sck,
   output logic      o_cs_b,
   output logic      o_si,
   output logic      o_hold_b,
   input  wire logic i_so,
   input  wire logic i_so_oe
);
   logic oe_in_hold;

   // The clock stands low between frames, as a real master leaves it.
   initial begin
      o_sck      = 1'b0;
      o_cs_b     = 1'b1;
      o_si       = 1'b1;
      o_hold_b   = 1'b1;
      oe_in_hold = 1'b0;
   end

   task automatic select(input logic v, input int dly);
      #13 o_cs_b = v;
      if (v)
         o_si = ~o_si;
      #(dly);
   endtask

   // A pause at bit hold_at carries one stray clock pulse and a flipped
   // data bit, so a device that does not ignore them loses alignment.
   task automatic xfer(input logic [7:0] d, input int hold_at,
                       output logic [7:0] q);
      for (int i = 7; i >= 0; i--) begin
         if (i == hold_at) begin
            #10 o_hold_b = 1'b0;
            #100 o_si = ~d[i];
            #32 o_sck = 1'b1;
            #32 o_sck = 1'b0;
            #400 oe_in_hold = i_so_oe;
            o_hold_b = 1'b1;
         end
         #10 o_si = d[i];
         #22 o_sck = 1'b1;
         q[i] = i_so;
         #32 o_sck = 1'b0;
      end
      o_si = ~o_si;
      #400;
   endtask
endmodule // spi_host_model

// ==== verif/tb_top.sv ====
`timescale 1ns/1ns

module tb_top;
   import spi_pin_pkg::*;

   localparam int unsigned WCYC = 8;

   logic       i_core_clk = 1'b0;
   logic       i_rst_b = 1'b0;
   logic       i_sck, i_cs_b, i_si, i_hold_b, o_so, o_so_oe;
   logic       i_wp_b = 1'b1;
   logic       i_read_mode = 1'b0;
   logic       i_write_seq_ok = 1'b0;
   logic       i_status_write = 1'b0;
   logic       i_protect_pin_enable_bit = 1'b0;
   logic       i_wren = 1'b0;
   logic [7:0] i_tx_data = 8'h00;
   logic       i_tx_valid = 1'b0;
   logic       i_rx_ready = 1'b1;
   logic       i_overrun_clr = 1'b0;
   logic [7:0] o_rx_data;
   logic       o_tx_ready, o_rx_valid, o_overrun, o_standby;
   logic       o_write_busy, o_write_start, o_status_write_en, o_wel;
   int         failures = 0;
   int         num_checks = 0;

   always #50 i_core_clk = ~i_core_clk;

   spi_host_model host (.o_sck(i_sck), .o_cs_b(i_cs_b), .o_si(i_si),
      .o_hold_b(i_hold_b), .i_so(o_so), .i_so_oe(o_so_oe));

   spi_pin_dev #(.WRITE_CYCLES(WCYC), .RX_DEPTH(FIFO_WORDS)) DUT (
      .i_core_clk, .i_rst_b, .i_core_en(1'b1), .i_sck, .i_cs_b, .i_si,
      .i_hold_b, .i_wp_b, .o_so, .o_so_oe, .i_read_mode, .i_write_seq_ok,
      .i_status_write, .i_protect_pin_enable_bit, .i_wren, .i_tx_data,
      .i_tx_valid, .o_tx_ready, .o_rx_data, .o_rx_valid, .i_rx_ready,
      .o_overrun, .i_overrun_clr, .o_standby, .o_write_busy,
      .o_write_start, .o_status_write_en, .o_wel);

   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] seen,
                      input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge i_core_clk);
   endtask

   task automatic t_reset();
      chk("standby", o_standby, 1);
      chk("wel", o_wel, 0);
      chk("so_oe", o_so_oe, 0);
      chk("tx_ready", o_tx_ready, 1);
      $display("reset test done");
   endtask

   task automatic t_read();
      logic [7:0] q;
      cyc(1);
      i_read_mode = 1'b1;
      i_tx_data   = 8'h3C;
      i_tx_valid  = 1'b1;
      cyc(1);
      i_tx_valid = 1'b0;
      host.select(1'b0, 500);
      chk("so_oe on", o_so_oe, 1);
      chk("standby sel", o_standby, 0);
      // The first byte of a frame is the command; data follows it.
      host.xfer(8'h5A, -1, q);
      host.xfer(8'hA5, 4, q);
      chk("read byte", q, 8'h3C);
      chk("oe in hold", host.oe_in_hold, 0);
      host.select(1'b1, 500);
      chk("so_oe off", o_so_oe, 0);
      chk("standby desel", o_standby, 1);
      cyc(1);
      i_read_mode = 1'b0;
      $display("read test done");
   endtask

   // The consumer stalls until one byte more than the depth has arrived.
   task automatic t_fifo();
      logic [7:0] q;
      cyc(1);
      i_rx_ready = 1'b0;
      host.select(1'b0, 500);
      for (int k = 0; k < 9; k++)
         host.xfer(8'h81 + 8'(k), -1, q);
      host.select(1'b1, 500);
      cyc(1);
      chk("overrun", o_overrun, 1);
      for (int k = 0; k < 8; k++) begin
         chk("rx valid", o_rx_valid, 1);
         chk("rx data", o_rx_data, 8'h81 + 8'(k));
         i_rx_ready = 1'b1;
         cyc(1);
         i_rx_ready = 1'b0;
         cyc(2);
      end
      chk("rx empty", o_rx_valid, 0);
      i_overrun_clr = 1'b1;
      cyc(1);
      i_overrun_clr = 1'b0;
      cyc(1);
      chk("overrun clr", o_overrun, 0);
      i_rx_ready = 1'b1;
      $display("fifo test done");
   endtask

   task automatic t_write(input logic wren, input logic pe,
                          input logic wp, input logic exp_en);
      logic [7:0] q;
      logic       seen;
      int         n;
      cyc(1);
      i_protect_pin_enable_bit = pe;
      i_wp_b = wp;
      i_write_seq_ok = 1'b1;
      i_status_write = 1'b1;
      i_wren = wren;
      cyc(1);
      i_wren = 1'b0;
      cyc(1);
      chk("wel set", o_wel, {7'h00, wren});
      host.select(1'b0, 500);
      host.xfer(8'hC3, -1, q);
      host.select(1'b1, 0);
      seen = 1'b0;
      for (n = 0; n < 20 && !seen; n++) begin
         cyc(1);
         seen = (o_write_start === 1'b1);
      end
      chk("start", {7'h00, seen}, {7'h00, wren});
      if (seen) begin
         cyc(1);
         chk("busy", o_write_busy, 1);
         chk("stat en", o_status_write_en, exp_en);
         chk("standby busy", o_standby, 0);
         i_wp_b = 1'b0;
         for (n = 1; n < 100 && o_write_busy === 1'b1; n++) begin
            chk("stat hold", o_status_write_en, exp_en);
            cyc(1);
         end
         chk("busy len", 8'(n), 8'(WCYC));
         cyc(2);
         chk("wel clr", o_wel, 0);
         chk("standby end", o_standby, 1);
      end
      i_write_seq_ok = 1'b0;
      i_status_write = 1'b0;
      $display("write test done");
   endtask

   initial begin
      #2000000;
      failures++;
      summarize();
   end

   initial begin
      repeat (3) @(posedge i_core_clk);
      @(negedge i_core_clk);
      t_reset();
      i_rst_b = 1'b1;
      cyc(5);
      t_read();
      t_fifo();
      t_write(1'b1, 1'b0, 1'b0, 1'b1);
      t_write(1'b1, 1'b1, 1'b0, 1'b0);
      t_write(1'b1, 1'b1, 1'b1, 1'b1);
      t_write(1'b0, 1'b1, 1'b1, 1'b0);
      summarize();
   end
endmodule // tb_top
